// ---- tbid_asserts.sv ----
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module tbid_asserts (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [11:0] instr_word,
    input wire logic [1:0] osc_phase,
    input wire logic dest_to_file,
    input wire logic [6:0] file_addr,
    input wire logic [7:0] bit_mask,
    input wire logic [8:0] literal,
    input wire logic lit_is_jump,
    input wire logic pc_write,
    input wire logic pc_bit8_clear,
    input wire logic flush_cycle
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // capture edge: phase 0 outside a flush cycle
    wire cap = clk_en && osc_phase == 2'h0 && !flush_cycle;
    a_phase_step: assert property (clk_en |=> osc_phase == 2'($past(osc_phase) + 1))
        else $error("phase step");
    a_dest_bit: assert property (cap |=> dest_to_file == $past(instr_word[5]))
        else $error("dest bit");
    a_file_rng: assert property (cap |=> file_addr == {2'h0, $past(instr_word[4:0])})
        else $error("file addr");
    a_bit_sel: assert property (cap |=> bit_mask == (8'h01 << $past(instr_word[7:5])))
        else $error("bit mask");
    a_lit_fmt: assert property (cap |=> literal == (lit_is_jump ?
        $past(instr_word[8:0]) : {1'h0, $past(instr_word[7:0])})) else $error("literal");
    // fields only move at a capture edge
    a_fld_hold: assert property (osc_phase != 2'h0 |=> $stable(literal) && $stable(file_addr))
        else $error("field moved");
    a_pc_bit8: assert property (pc_write |-> pc_bit8_clear == !lit_is_jump)
        else $error("pc bit8");
    a_flush_len: assert property ($rose(flush_cycle) |-> flush_cycle[*4] ##1 !flush_cycle)
        else $error("flush length");
endmodule : tbid_asserts
bind tbid_decode tbid_asserts tbid_asserts_i (.*);

// ---- tbid_decode.sv ----
// twelve-bit instruction decoder with instruction-cycle timing
`timescale 1ns/1ps
`include "tbid_regs.svh"
module tbid_decode
    import tbid_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [11:0] instr_word,
    input wire logic test_true,
    output logic fetch_req,
    output logic [1:0] osc_phase,
    output logic cycle_strobe,
    output logic [1:0] instr_class,
    output logic [5:0] opcode,
    output logic dest_to_file,
    output logic [6:0] file_addr,
    output logic [2:0] bit_index,
    output logic [7:0] bit_mask,
    output logic [8:0] literal,
    output logic lit_is_jump,
    output logic pc_write,
    output logic pc_bit8_clear,
    output logic is_skip_test,
    output logic flush_cycle
);
    // all decoder state except the quarter count in one record: the cycle state plus the latched fields
    typedef struct packed {
        tbid_state_t state;
        logic [1:0] cls;
        logic [5:0] opc;
        logic dest;
        logic [6:0] faddr;
        logic [2:0] bidx;
        logic [7:0] bmask;
        logic [8:0] lit;
        logic jump;
        logic pcw;
        logic pc8clr;
        logic skip;
    } tbid_dec_st_t;

    tbid_dec_st_t st_ff;
    tbid_dec_st_t nxt_st;
    logic [1:0] phase;
    logic cyc_start;
    logic cyc_end;
    logic [11:0] w;
    tbid_class_t cls_c;
    logic pcw_c;
    logic skip_c;

    // quarter counter shared by fetch, capture and the cycle strobe
    tbid_phase u_phase (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .phase(phase),
        .cycle_start(cyc_start),
        .cycle_end(cyc_end)
    );

    assign w = instr_word;

    // classify on the top nibble: each group gives its class, whether it is a
    // conditional skip and whether it rewrites the program counter
    always_comb begin
        cls_c = TBID_CLS_BYTE;
        pcw_c = 1'h0;
        skip_c = 1'h0;
        case (w[11:8])
            // byte group, including the all-zero control words
            4'h0: begin
                cls_c = TBID_CLS_BYTE;
            end
            4'h1: begin
                cls_c = TBID_CLS_BYTE;
            end
            4'h2: begin
                cls_c = TBID_CLS_BYTE;
                skip_c = (w[7:6] == 2'h3); // decrement, skip if zero
            end
            4'h3: begin
                cls_c = TBID_CLS_BYTE;
                skip_c = (w[7:6] == 2'h3); // increment, skip if zero
            end
            // bit group: clear, set, then the two bit tests
            4'h4: begin
                cls_c = TBID_CLS_BIT;
            end
            4'h5: begin
                cls_c = TBID_CLS_BIT;
            end
            4'h6: begin
                cls_c = TBID_CLS_BIT;
                skip_c = 1'h1; // skip if clear
            end
            4'h7: begin
                cls_c = TBID_CLS_BIT;
                skip_c = 1'h1; // skip if set
            end
            // return and call rewrite the program counter
            4'h8: begin
                cls_c = TBID_CLS_LIT;
                pcw_c = 1'h1;
            end
            4'h9: begin
                cls_c = TBID_CLS_LIT;
                pcw_c = 1'h1;
            end
            // the jump: bit 8 already belongs to its literal
            4'hA: begin
                cls_c = TBID_CLS_JMP;
                pcw_c = 1'h1;
            end
            4'hB: begin
                cls_c = TBID_CLS_JMP;
                pcw_c = 1'h1;
            end
            // literal arithmetic and moves stay single-cycle
            4'hC: begin
                cls_c = TBID_CLS_LIT;
            end
            4'hD: begin
                cls_c = TBID_CLS_LIT;
            end
            4'hE: begin
                cls_c = TBID_CLS_LIT;
            end
            4'hF: begin
                cls_c = TBID_CLS_LIT;
            end
            // an unknown word decodes as a plain byte op, never as a pc write
            default: begin
                cls_c = TBID_CLS_BYTE;
            end
        endcase
    end

    // two-cycle control: a taken skip or a pc write makes the next cycle a
    // flush cycle, in which the word fetched behind it is thrown away
    always_comb begin
        nxt_st = st_ff;
        case (st_ff.state)
            TBID_ST_FIRST: begin
                if (cyc_end && (st_ff.pcw || (st_ff.skip && test_true))) begin
                    nxt_st.state = TBID_ST_SECOND;
                end
            end
            TBID_ST_SECOND: begin
                // the flush cycle always ends after its own four periods
                if (cyc_end) begin
                    nxt_st.state = TBID_ST_FIRST;
                end
            end
            default: begin
                nxt_st.state = TBID_ST_FIRST;
            end
        endcase
        // fields latch only at the start of a first cycle, so they hold for four periods, or eight when a flush cycle follows
        if (cyc_start && st_ff.state == TBID_ST_FIRST) begin
            nxt_st.cls = cls_c;
            nxt_st.opc = w[11:6];
            nxt_st.dest = w[`TBID_DEST_BIT];
            // 5-bit index zero-extended inside the 0x00..0x7F space
            nxt_st.faddr = {2'h0, w[`TBID_FILE_HI:0]} & `TBID_FILE_MAX;
            nxt_st.bidx = w[`TBID_BIT_HI:`TBID_BIT_LO];
            nxt_st.bmask = 8'h01 << w[`TBID_BIT_HI:`TBID_BIT_LO];
            // the jump keeps nine literal bits, every other literal keeps eight
            if (cls_c == TBID_CLS_JMP) begin
                nxt_st.lit = w[`TBID_JMP_HI:0];
            end else begin
                nxt_st.lit = {1'h0, w[`TBID_LIT8_HI:0]};
            end
            nxt_st.jump = (cls_c == TBID_CLS_JMP);
            nxt_st.pcw = pcw_c;
            nxt_st.pc8clr = pcw_c && (cls_c != TBID_CLS_JMP);
            // ignored bits (such as the low bits of control words) never reach a decision
            nxt_st.skip = skip_c;
        end
    end

    // clock enable low freezes the cycle state and every latched field
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // handshake strobes come straight from the phase, data fields from flops
    assign fetch_req = cyc_start;
    assign osc_phase = phase;
    assign cycle_strobe = cyc_end;
    assign instr_class = st_ff.cls;
    assign opcode = st_ff.opc;
    assign dest_to_file = st_ff.dest;
    assign file_addr = st_ff.faddr;
    assign bit_index = st_ff.bidx;
    assign bit_mask = st_ff.bmask;
    assign literal = st_ff.lit;
    assign lit_is_jump = st_ff.jump;
    assign pc_write = st_ff.pcw;
    assign pc_bit8_clear = st_ff.pc8clr;
    assign is_skip_test = st_ff.skip;
    assign flush_cycle = (st_ff.state == TBID_ST_SECOND);
endmodule : tbid_decode

// ---- tbid_mem.sv ----
// program memory model feeding the decoder
`timescale 1ns/1ps
module tbid_mem (
    input wire logic fetch_req,
    input wire logic [11:0] word,
    output logic [11:0] instr_word
);
    // inverted outside fetch so a late sample never sees a stale word
    assign instr_word = fetch_req ? word : ~word;
endmodule : tbid_mem

// ---- tbid_phase.sv ----
// quarter counter: four oscillator periods make one instruction cycle
`timescale 1ns/1ps
`include "tbid_regs.svh"
module tbid_phase (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    output logic [1:0] phase,
    output logic cycle_start,
    output logic cycle_end
);
    typedef struct packed {
        logic [1:0] cnt;
    } tbid_phase_st_t;

    tbid_phase_st_t st_ff;
    tbid_phase_st_t nxt_st;

    // wraps after exactly four periods
    always_comb begin
        nxt_st = st_ff;
        if (st_ff.cnt == 2'(`TBID_OSC_PER_CYCLE - 1)) begin
            nxt_st.cnt = 2'h0;
        end else begin
            nxt_st.cnt = st_ff.cnt + 2'h1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign phase = st_ff.cnt;
    assign cycle_start = (st_ff.cnt == 2'h0);
    assign cycle_end = (st_ff.cnt == 2'(`TBID_OSC_PER_CYCLE - 1));
endmodule : tbid_phase

// ---- tbid_pkg.sv ----
// types shared by the twelve-bit instruction decoder
package tbid_pkg;
    typedef enum logic [1:0] {
        TBID_CLS_BYTE = 2'b00,
        TBID_CLS_BIT = 2'b01,
        TBID_CLS_LIT = 2'b10,
        TBID_CLS_JMP = 2'b11
    } tbid_class_t;

    typedef enum logic [0:0] {
        TBID_ST_FIRST = 1'b0,
        TBID_ST_SECOND = 1'b1
    } tbid_state_t;
endpackage : tbid_pkg

// ---- tbid_regs.svh ----
// constants for the twelve-bit instruction decoder: field positions, timing counts
`ifndef TBID_REGS_SVH
`define TBID_REGS_SVH
`define TBID_WORD_W 12
`define TBID_OSC_PER_CYCLE 4
`define TBID_DEST_BIT 5
`define TBID_FILE_HI 4
`define TBID_BIT_HI 7
`define TBID_BIT_LO 5
`define TBID_LIT8_HI 7
`define TBID_JMP_HI 8
`define TBID_FILE_MAX 7'h7F
`define TBID_NOP_WORD 12'h000
`endif

// ---- tbid_tb.sv ----
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module twelve_bit_instruction_decode_tb;
    logic core_clk = 0, reset_n = 0, clk_en = 1, test_true = 0;
    logic [11:0] word = 12'h000, instr_word;
    logic [1:0] osc_phase, instr_class;
    logic [5:0] opcode;
    logic [6:0] file_addr;
    logic [2:0] bit_index;
    logic [7:0] bit_mask;
    logic [8:0] literal;
    logic fetch_req, cycle_strobe, dest_to_file, lit_is_jump, pc_write;
    logic pc_bit8_clear, is_skip_test, flush_cycle;
    int err_count = 0, checked = 0;
    tbid_decode tbid_decode_i (.*);
    tbid_mem tbid_mem_i (.*);
    initial forever #5 core_clk = ~core_clk;
    task chk(input logic [11:0] s, input logic [11:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    // word is held until the decoder takes it, fields read one edge later
    task go(input logic [11:0] w, input logic t);
        @(posedge core_clk) word <= w;
        test_true <= t;
        do @(negedge core_clk); while (!(fetch_req && !flush_cycle));
        @(negedge core_clk);
    endtask : go
    task t_byte;
        go(12'h1FF, 1'h0);
        chk(dest_to_file, 12'h001);
        chk(file_addr, 12'h01F);
        chk(opcode, 12'h007);
        chk(instr_class, 12'h000);
        go(12'h1C5, 1'h0);
        chk(dest_to_file, 12'h000);
        $display("byte test done");
    endtask : t_byte
    task t_lit;
        go(12'hC5A, 1'h0);
        chk(literal, 12'h05A);
        go(12'hBA5, 1'h0);
        chk(literal, 12'h1A5);
        chk(pc_bit8_clear, 12'h000);
        repeat (3) @(negedge core_clk);
        chk(flush_cycle, 12'h001);
        go(12'h912, 1'h0);
        chk(pc_bit8_clear, 12'h001);
        chk(literal, 12'h012);
        go(12'h9FF, 1'h0);
        chk(instr_class, 12'h002);
        chk(pc_write, 12'h001);
        $display("literal test done");
    endtask : t_lit
    task t_skip;
        go(12'h7E3, 1'h1);
        chk(bit_mask, 12'h080);
        chk(bit_index, 12'h007);
        chk(is_skip_test, 12'h001);
        repeat (3) @(negedge core_clk);
        chk(flush_cycle, 12'h001);
        go(12'h6E3, 1'h0);
        repeat (3) @(negedge core_clk);
        chk(flush_cycle, 12'h000);
        $display("skip test done");
    endtask : t_skip
    // enable dropped for three edges mid-instruction: phase and fields freeze
    task t_hold;
        go(12'h2A9, 1'h0);
        chk(osc_phase, 12'h001);
        chk(fetch_req, 12'h000);
        @(posedge core_clk) clk_en <= 1'h0;
        repeat (3) @(negedge core_clk);
        chk(osc_phase, 12'h002);
        chk(file_addr, 12'h009);
        @(posedge core_clk) clk_en <= 1'h1;
        repeat (2) @(negedge core_clk);
        chk(cycle_strobe, 12'h001);
        chk(dest_to_file, 12'h001);
        $display("hold test done");
    endtask : t_hold
    task end_of_test;
        $display("compares %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'h1;
        t_byte;
        t_lit;
        t_skip;
        t_hold;
        end_of_test;
    end
    // whole run needs about 70 cycles
    initial begin
        repeat (2000) @(posedge core_clk);
        err_count++;
        end_of_test;
    end
endmodule : twelve_bit_instruction_decode_tb
